// ---- src/flash_ctrl_pkg.sv ----
// Purpose: constants shared by the flash command controller and its parts
// Assumes: byte-wide register file port, 100 MHz system clock
// Notes:   flash array modelled by a small synchronous memory
// Overview of operation
// R1 - 73H then 8CH are the unlock codes
// R2 - 95H erases page, 63H erases all
// R3 - 5EH maps sector protect onto FF9H
// R4 - 00H resets, leaves programming, relocks controller
// R5 - sector protect readable and writable at FF9H
// R6 - FF8H writes command, reads status
// R7 - write protect option blocks program and erase
// R8 - unlocked writes inside unlocked page program bytes
// R9 - erased byte is FFH; program only clears
// R10 - only erase returns bits to one
// R11 - CPU held idle while byte programs
// R12 - interrupts held pending until program completes
// R13 - no programming of pages in protected sectors
// R14 - writes outside unlocked page are ignored
// R15 - software programs a location at most twice
// R16 - software writes 00H, page, then 73H
// R17 - option byte survives reset unchanged
// R18 - option bit 7 selects watchdog timeout action
// R19 - option bit 6 forces watchdog always on
// R20 - option bits 5:4 select oscillator mode
// R21 - option bit 3 keeps brownout on in stop
// R22 - option bit 2 clear read-protects user code
// R23 - second unlock must directly follow the first
`default_nettype none
package flash_ctrl_pkg;
  localparam logic [11:0] ADDR_CMD_STAT  = 12'hFF8;
  localparam logic [11:0] ADDR_PAGE_PROT = 12'hFF9;
  localparam logic [7:0]  CMD_RESET      = 8'h00;
  localparam logic [7:0]  CMD_UNLOCK1    = 8'h73;
  localparam logic [7:0]  CMD_UNLOCK2    = 8'h8C;
  localparam logic [7:0]  CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0]  CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0]  CMD_PROT_SEL   = 8'h5E;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [7:0]  CMD_RESET_VAL  = 8'h00;
  localparam logic [7:0]  PROT_RESET_VAL = 8'h00;
  localparam logic [7:0]  PAGE_RESET_VAL = 8'h00;
  localparam int          OPT_WATCHDOG_TIMEOUT_ACTION    = 7;
  localparam int          OPT_WATCHDOG_ALWAYS_ON     = 6;
  localparam int          OPT_OSC_HI     = 5;
  localparam int          OPT_OSC_LO     = 4;
  localparam int          OPT_BROWNOUT_ALWAYS_ON     = 3;
  localparam int          OPT_RP         = 2;
  localparam int          OPT_FWP        = 0;
  localparam int          PROG_TIME_NS   = 40;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          PROG_CYCLES    =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ERASE_TIME_NS  = 80;
  localparam int          ERASE_CYCLES   =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // status codes shown in the low six bits of the status register
  localparam logic [5:0]  ST_LOCKED      = 6'h00;
  localparam logic [5:0]  ST_FIRST_OK    = 6'h01;
  localparam logic [5:0]  ST_UNLOCKED    = 6'h02;
  localparam logic [5:0]  ST_PROT_SEL    = 6'h03;
  localparam logic [5:0]  ST_PROGRAM     = 6'h08;
  localparam logic [5:0]  ST_PAGE_ERASE  = 6'h10;
  localparam logic [5:0]  ST_MASS_ERASE  = 6'h18;
  typedef enum logic [2:0] {
    S_LOCKED  = 3'b000,
    S_FIRST   = 3'b001,
    S_OPEN    = 3'b010,
    S_PROT    = 3'b011,
    S_PROG    = 3'b100,
    S_PERASE  = 3'b101,
    S_MERASE  = 3'b110
  } ctl_state_t;
endpackage
`default_nettype wire

// ---- src/flash_mem_if.sv ----
// Purpose: carrier between controller and flash array
// Assumes: one clock, one access per cycle
// Notes:   write only clears bits; erase fills with ones
`default_nettype none
interface flash_mem_if #(parameter int AW = 8);
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic          prog;
  logic          erase_all;
  logic          erase_page;
  logic [7:0]    rdata;
  modport ctl (output addr, output wdata, output prog, output erase_all,
               output erase_page, input rdata);
  modport mem (input addr, input wdata, input prog, input erase_all,
               input erase_page, output rdata);
endinterface
`default_nettype wire

// ---- src/flash_array.sv ----
// Purpose: small flash array model with page and mass erase
// Assumes: PAGE_W low address bits select a byte within a page
// Notes:   location 0 holds the option byte; power-up content is erased
`default_nettype none
module flash_array #(
  parameter int AW     = 8,
  parameter int PAGE_W = 4
) (
  input  wire logic clk,
  flash_mem_if.mem  fm
);
  // power-up content is erased; a declaration value keeps one writer
  logic [7:0] mem_r [2**AW] = '{default: flash_ctrl_pkg::ERASED_BYTE};
  logic [7:0] rdata_r;

  // no reset here: contents, the option byte among them, survive reset
  always_ff @(posedge clk) begin // [R17]
    for (int i = 0; i < 2**AW; i++) begin
      if (fm.erase_all ||
          (fm.erase_page && i[AW-1:PAGE_W] == fm.addr[AW-1:PAGE_W])) begin
        mem_r[i] <= flash_ctrl_pkg::ERASED_BYTE; // [R10]
      end else if (fm.prog && i[AW-1:0] == fm.addr) begin
        mem_r[i] <= mem_r[i] & fm.wdata; // [R9]
      end
    end
    rdata_r <= mem_r[fm.addr];
  end
  assign fm.rdata = rdata_r;
endmodule
`default_nettype wire

// ---- src/flash_command_controller.sv ----
// Purpose: flash command decode, unlock, program and erase gating
// Assumes: CPU register port and flash write port on clk; option byte
//          sampled from array location 0 after reset
// Notes:   sector is the upper page bits; one protect bit per sector
`default_nettype none
module flash_command_controller #(
  parameter int AW     = 8,
  parameter int PAGE_W = 4
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_rd,
  output logic      [7:0]  mem_rdata,
  output logic             cpu_hold,
  output logic             irq_defer,
  output logic             watchdog_timeout_action,
  output logic             watchdog_always_on,
  output logic      [1:0]  oscillator_mode_select,
  output logic             brownout_always_on,
  output logic             code_read_protect,
  output logic             flash_write_protect
);
  localparam int PG_BITS = AW - PAGE_W;
  localparam logic [3:0] BUSY_PROG  = 4'(flash_ctrl_pkg::PROG_CYCLES);
  localparam logic [3:0] BUSY_ERASE = 4'(flash_ctrl_pkg::ERASE_CYCLES);

  flash_mem_if #(.AW(AW)) fm ();
  flash_array #(.AW(AW), .PAGE_W(PAGE_W)) u_array (
    .clk (clk),
    .fm  (fm)
  );

  function automatic logic sect_prot(input logic [7:0] prot,
                                     input logic [PG_BITS-1:0] pg);
    logic [2:0] s;
    s = 3'(pg >> (PG_BITS > 3 ? PG_BITS - 3 : 0));
    return prot[s];
  endfunction

  flash_ctrl_pkg::ctl_state_t state_r, state_nxt;
  logic [7:0]         page_r, page_nxt;
  logic [7:0]         prot_r, prot_nxt;
  logic [3:0]         busy_r, busy_nxt;
  logic [AW-1:0]      op_addr_r, op_addr_nxt;
  logic [7:0]         op_data_r, op_data_nxt;
  logic [7:0]         opt_r, opt_nxt;
  logic [1:0]         opt_phase_r, opt_phase_nxt;
  logic [7:0]         rdata_r, rdata_nxt;

  logic cmd_wr, pp_wr, pp_rd, st_rd, in_page, page_ok;
  logic [PG_BITS-1:0] cur_page;

  assign cmd_wr   = reg_wr && reg_addr == flash_ctrl_pkg::ADDR_CMD_STAT;
  assign pp_wr    = reg_wr && reg_addr == flash_ctrl_pkg::ADDR_PAGE_PROT;
  assign pp_rd    = reg_rd && reg_addr == flash_ctrl_pkg::ADDR_PAGE_PROT;
  assign st_rd    = reg_rd && reg_addr == flash_ctrl_pkg::ADDR_CMD_STAT;
  assign cur_page = page_r[PG_BITS-1:0];
  assign in_page  = mem_addr[AW-1:PAGE_W] == cur_page; // [R14]
  // protected sector or write-protect option blocks every change
  assign page_ok  = !sect_prot(prot_r, cur_page) &&
                    !opt_r[flash_ctrl_pkg::OPT_FWP]; // [R7] [R13]

  always_comb begin
    state_nxt   = state_r;
    page_nxt    = page_r;
    prot_nxt    = prot_r;
    busy_nxt    = busy_r;
    op_addr_nxt = op_addr_r;
    op_data_nxt = op_data_r;
    if (busy_r != 4'h0) begin
      busy_nxt = busy_r - 4'h1;
      if (busy_r == 4'h1) begin
        state_nxt = flash_ctrl_pkg::S_OPEN;
      end
    end else if (cmd_wr) begin
      // any command write other than the matching next code or 5EH relocks
      case (reg_wdata)
        flash_ctrl_pkg::CMD_RESET: begin
          state_nxt = flash_ctrl_pkg::S_LOCKED; // [R4]
        end
        flash_ctrl_pkg::CMD_UNLOCK1: begin
          state_nxt = (state_r == flash_ctrl_pkg::S_LOCKED) ?
                      flash_ctrl_pkg::S_FIRST :
                      flash_ctrl_pkg::S_LOCKED; // [R1] [R23]
        end
        flash_ctrl_pkg::CMD_UNLOCK2: begin
          state_nxt = (state_r == flash_ctrl_pkg::S_FIRST) ?
                      flash_ctrl_pkg::S_OPEN :
                      flash_ctrl_pkg::S_LOCKED; // [R1] [R23]
        end
        flash_ctrl_pkg::CMD_PAGE_ERASE: begin
          if (state_r == flash_ctrl_pkg::S_OPEN && page_ok) begin
            state_nxt   = flash_ctrl_pkg::S_PERASE; // [R2]
            busy_nxt    = BUSY_ERASE;
            op_addr_nxt = {cur_page, PAGE_W'(0)};
          end else begin
            state_nxt = flash_ctrl_pkg::S_LOCKED;
          end
        end
        flash_ctrl_pkg::CMD_MASS_ERASE: begin
          if (state_r == flash_ctrl_pkg::S_OPEN &&
              !opt_r[flash_ctrl_pkg::OPT_FWP] && prot_r == 8'h00) begin
            state_nxt = flash_ctrl_pkg::S_MERASE; // [R2] [R7]
            busy_nxt  = BUSY_ERASE;
          end else begin
            state_nxt = flash_ctrl_pkg::S_LOCKED;
          end
        end
        flash_ctrl_pkg::CMD_PROT_SEL: begin
          state_nxt = flash_ctrl_pkg::S_PROT; // [R3]
        end
        default: begin
          state_nxt = flash_ctrl_pkg::S_LOCKED;
        end
      endcase
    end else if (pp_wr) begin
      if (state_r == flash_ctrl_pkg::S_PROT) begin
        prot_nxt = prot_r | reg_wdata; // [R5]
      end else begin
        page_nxt = reg_wdata;
      end
    end else if (mem_wr && state_r == flash_ctrl_pkg::S_OPEN &&
                 in_page && page_ok) begin
      state_nxt   = flash_ctrl_pkg::S_PROG; // [R8]
      busy_nxt    = BUSY_PROG;
      op_addr_nxt = mem_addr;
      op_data_nxt = mem_wdata;
    end
  end

  always_comb begin
    fm.addr       = mem_addr;
    fm.wdata      = op_data_r;
    fm.prog       = 1'b0;
    fm.erase_all  = 1'b0;
    fm.erase_page = 1'b0;
    if (opt_phase_r != 2'd2) begin
      fm.addr = '0;
    end else if (busy_r == 4'h1) begin
      fm.addr       = op_addr_r;
      fm.prog       = state_r == flash_ctrl_pkg::S_PROG; // [R9]
      fm.erase_page = state_r == flash_ctrl_pkg::S_PERASE; // [R10]
      fm.erase_all  = state_r == flash_ctrl_pkg::S_MERASE; // [R10]
    end
  end

  // option byte read after reset and again after location 0 is programmed or erased; reset never writes the array
  always_comb begin
    opt_nxt       = opt_r;
    opt_phase_nxt = opt_phase_r;
    if (opt_phase_r == 2'd1) begin
      opt_nxt = fm.rdata; // [R17]
    end
    if (opt_phase_r != 2'd2) begin
      opt_phase_nxt = opt_phase_r + 2'd1;
    end else if (fm.erase_all ||
                 (fm.erase_page && op_addr_r[AW-1:PAGE_W] == '0) ||
                 (fm.prog && op_addr_r == '0)) begin
      opt_phase_nxt = 2'd0;
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (st_rd) begin // [R6]
      case (state_r)
        flash_ctrl_pkg::S_FIRST:
          rdata_nxt = {2'b00, flash_ctrl_pkg::ST_FIRST_OK};
        flash_ctrl_pkg::S_OPEN:
          rdata_nxt = {2'b00, flash_ctrl_pkg::ST_UNLOCKED};
        flash_ctrl_pkg::S_PROT:
          rdata_nxt = {2'b00, flash_ctrl_pkg::ST_PROT_SEL};
        flash_ctrl_pkg::S_PROG:
          rdata_nxt = {2'b00, flash_ctrl_pkg::ST_PROGRAM};
        flash_ctrl_pkg::S_PERASE:
          rdata_nxt = {2'b00, flash_ctrl_pkg::ST_PAGE_ERASE};
        flash_ctrl_pkg::S_MERASE:
          rdata_nxt = {2'b00, flash_ctrl_pkg::ST_MASS_ERASE};
        default:
          rdata_nxt = {2'b00, flash_ctrl_pkg::ST_LOCKED};
      endcase
    end else if (pp_rd) begin
      // protect select swaps which register answers at the shared address
      rdata_nxt = (state_r == flash_ctrl_pkg::S_PROT) ?
                  prot_r : page_r; // [R5]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r     <= flash_ctrl_pkg::S_LOCKED;
      page_r      <= flash_ctrl_pkg::PAGE_RESET_VAL;
      prot_r      <= flash_ctrl_pkg::PROT_RESET_VAL;
      busy_r      <= 4'h0;
      op_addr_r   <= '0;
      op_data_r   <= flash_ctrl_pkg::ERASED_BYTE;
      opt_r       <= flash_ctrl_pkg::ERASED_BYTE;
      opt_phase_r <= 2'd0;
      rdata_r     <= 8'h00;
    end else begin
      state_r     <= state_nxt;
      page_r      <= page_nxt;
      prot_r      <= prot_nxt;
      busy_r      <= busy_nxt;
      op_addr_r   <= op_addr_nxt;
      op_data_r   <= op_data_nxt;
      opt_r       <= opt_nxt;
      opt_phase_r <= opt_phase_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  // array data pass through one register stage; read-protect is applied
  // by the debugger, not here
  assign mem_rdata = mem_rd ? fm.rdata : 8'h00;
  // hold CPU and defer interrupts for the whole operation
  assign cpu_hold  = busy_r != 4'h0 || opt_phase_r != 2'd2; // [R11]
  assign irq_defer = busy_r != 4'h0; // [R12]
  assign watchdog_timeout_action =
    opt_r[flash_ctrl_pkg::OPT_WATCHDOG_TIMEOUT_ACTION]; // [R18]
  assign watchdog_always_on = !opt_r[flash_ctrl_pkg::OPT_WATCHDOG_ALWAYS_ON]; // [R19]
  assign oscillator_mode_select =
    opt_r[flash_ctrl_pkg::OPT_OSC_HI:flash_ctrl_pkg::OPT_OSC_LO]; // [R20]
  assign brownout_always_on = opt_r[flash_ctrl_pkg::OPT_BROWNOUT_ALWAYS_ON]; // [R21]
  assign code_read_protect = !opt_r[flash_ctrl_pkg::OPT_RP]; // [R22]
  assign flash_write_protect = opt_r[flash_ctrl_pkg::OPT_FWP]; // [R7]

  unlock_order_a: assert property (@(posedge clk) disable iff (srst)
    state_r == flash_ctrl_pkg::S_OPEN && $past(state_r) ==
    flash_ctrl_pkg::S_LOCKED |-> 1'b0)
    else $error("unlocked without first code"); // [R1] [R23]
  relock_cmd_a: assert property (@(posedge clk) disable iff (srst)
    cmd_wr && reg_wdata == 8'h00 && busy_r == 4'h0 |=>
    state_r == flash_ctrl_pkg::S_LOCKED)
    else $error("reset command did not relock"); // [R4]
  erase_start_a: assert property (@(posedge clk) disable iff (srst)
    cmd_wr && reg_wdata == 8'h95 && state_r == flash_ctrl_pkg::S_OPEN &&
    busy_r == 4'h0 && page_ok |=> state_r == flash_ctrl_pkg::S_PERASE)
    else $error("page erase not started"); // [R2]
  prot_select_a: assert property (@(posedge clk) disable iff (srst)
    cmd_wr && reg_wdata == 8'h5E && busy_r == 4'h0 |=>
    state_r == flash_ctrl_pkg::S_PROT)
    else $error("protect select not taken"); // [R3]
  fwp_block_a: assert property (@(posedge clk) disable iff (srst)
    opt_r[flash_ctrl_pkg::OPT_FWP] |-> !fm.prog && !fm.erase_page &&
    !fm.erase_all)
    else $error("flash changed under write protect"); // [R7]
  prog_hold_a: assert property (@(posedge clk) disable iff (srst)
    $rose(state_r == flash_ctrl_pkg::S_PROG) |->
    (cpu_hold && irq_defer)[*4])
    else $error("cpu not held during program"); // [R11] [R12]
  out_page_a: assert property (@(posedge clk) disable iff (srst)
    mem_wr && !in_page && busy_r == 4'h0 && !cmd_wr && !pp_wr |=>
    state_r != flash_ctrl_pkg::S_PROG)
    else $error("write outside page started program"); // [R14]
  prot_page_a: assert property (@(posedge clk) disable iff (srst)
    fm.prog |-> !sect_prot(prot_r, op_addr_r[AW-1:PAGE_W]))
    else $error("protected page programmed"); // [R13]
  status_read_a: assert property (@(posedge clk) disable iff (srst)
    st_rd && state_r == flash_ctrl_pkg::S_OPEN |=> reg_rdata == 8'h02)
    else $error("status read wrong"); // [R6]
endmodule
`default_nettype wire

// ---- test/cpu_model.sv ----
// Purpose: CPU side model driving the register and flash write ports
// Assumes: every request starts just after a rising edge
// Notes:   idle address and data lines show the inverse of the last value
`default_nettype none
module cpu_model (
  input  wire logic        clk,
  output logic      [11:0] reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_wdata,
  output logic      [7:0]  mem_addr,
  output logic             mem_wr,
  output logic             mem_rd,
  output logic      [7:0]  mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    mem_addr = 8'h00;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    mem_wdata = 8'h00;
  end
  task automatic reg_op(input logic wr, input logic [11:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  // reads hold the strobe a second cycle since the data gate follows it
  task automatic mem_op(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    mem_wr    <= wr;
    mem_rd    <= ~wr;
    mem_addr  <= a;
    mem_wdata <= d;
    @(posedge clk);
    mem_wr    <= 1'b0;
    if (!wr) @(posedge clk);
    mem_rd    <= 1'b0;
    mem_addr  <= ~a;
    mem_wdata <= ~d;
  endtask
  task automatic open_page(input logic [7:0] pg);
    reg_op(1'b1, flash_ctrl_pkg::ADDR_CMD_STAT, flash_ctrl_pkg::CMD_RESET);
    reg_op(1'b1, flash_ctrl_pkg::ADDR_PAGE_PROT, pg);
    reg_op(1'b1, flash_ctrl_pkg::ADDR_CMD_STAT, flash_ctrl_pkg::CMD_UNLOCK1);
  endtask
endmodule
`default_nettype wire

// ---- test/flash_command_controller_bench.sv ----
// Purpose: self-checking bench for the flash command controller
// Assumes: array erased at power-up, so the option byte reads FFH
// Notes:   erased option byte sets write protect; writes must be refused
`default_nettype none
module flash_command_controller_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic       mem;
    logic [7:0] val;
  } note_t;
  localparam logic [11:0] CS = flash_ctrl_pkg::ADDR_CMD_STAT;
  localparam logic [11:0] PP = flash_ctrl_pkg::ADDR_PAGE_PROT;
  localparam logic [7:0]  FF = flash_ctrl_pkg::ERASED_BYTE;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] reg_addr;
  logic        reg_wr, reg_rd;
  logic [7:0]  reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
  logic        mem_wr, mem_rd, cpu_hold, irq_defer;
  logic        watchdog_timeout_action, watchdog_always_on;
  logic [1:0]  oscillator_mode_select;
  logic        brownout_always_on, code_read_protect, flash_write_protect;
  note_t       notes_q[$];
  note_t       n;
  logic        rd_seen = 1'b0;
  logic        mrd_seen = 1'b0;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [7:0]  opt, a, d;
  initial forever #5 clk = ~clk;
  flash_command_controller i_flash_command_controller (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .cpu_hold(cpu_hold),
    .irq_defer(irq_defer),
    .watchdog_timeout_action(watchdog_timeout_action),
    .watchdog_always_on(watchdog_always_on),
    .oscillator_mode_select(oscillator_mode_select),
    .brownout_always_on(brownout_always_on),
    .code_read_protect(code_read_protect),
    .flash_write_protect(flash_write_protect));
  cpu_model i_cpu_model (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t read %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_lvl(input logic [1:0] g, input logic [1:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t level %b expected %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] v);
    i_cpu_model.reg_op(1'b1, ad, v);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [7:0] e);
    notes_q.push_back('{1'b0, e});
    i_cpu_model.reg_op(1'b0, ad, 8'h00);
  endtask
  task automatic st(input logic [5:0] code);
    rd(CS, {2'b00, code});
  endtask
  task automatic mrd(input logic [7:0] ad, input logic [7:0] e);
    notes_q.push_back('{1'b1, e});
    i_cpu_model.mem_op(1'b0, ad, 8'h00);
  endtask
  // the array keeps its contents, so options must decode the same each time
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    opt = FF;
    cmp_lvl({1'b0, cpu_hold}, 2'b00);
    cmp_lvl({1'b0, watchdog_timeout_action}, {1'b0, opt[7]});
    cmp_lvl({1'b0, watchdog_always_on}, {1'b0, ~opt[6]});
    cmp_lvl(oscillator_mode_select, opt[5:4]);
    cmp_lvl({1'b0, brownout_always_on}, {1'b0, opt[3]});
    cmp_lvl({1'b0, code_read_protect}, {1'b0, ~opt[2]});
    cmp_lvl({1'b0, flash_write_protect}, {1'b0, opt[0]});
    mrd(8'h00, opt);
    st(flash_ctrl_pkg::ST_LOCKED);
  endtask
  always @(posedge clk) begin
    rd_seen  <= reg_rd;
    mrd_seen <= mem_rd;
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  always @(negedge clk) begin
    if (rd_seen || (mrd_seen && mem_rd)) begin
      if (notes_q.size() == 0) begin
        err_count++;
        $display("[FAIL] %0t unexpected read", $time);
      end else begin
        n = notes_q.pop_front();
        cmp_byte(n.mem ? mem_rdata : reg_rdata, n.val);
      end
    end
  end
  initial begin
    void'($urandom(80546));
    do_reset();
    a = {4'h3, 4'($urandom())};
    mrd(a, FF);
    $display("test reset_options done");
    wr(CS, flash_ctrl_pkg::CMD_UNLOCK2);
    st(flash_ctrl_pkg::ST_LOCKED);
    wr(CS, flash_ctrl_pkg::CMD_UNLOCK1);
    st(flash_ctrl_pkg::ST_FIRST_OK);
    wr(CS, flash_ctrl_pkg::CMD_RESET);
    wr(CS, flash_ctrl_pkg::CMD_UNLOCK2);
    st(flash_ctrl_pkg::ST_LOCKED);
    i_cpu_model.open_page(8'h03);
    wr(CS, flash_ctrl_pkg::CMD_UNLOCK2);
    st(flash_ctrl_pkg::ST_UNLOCKED);
    $display("test unlock_order done");
    d = 8'($urandom()) & 8'h7E;
    i_cpu_model.mem_op(1'b1, a, d);
    i_cpu_model.mem_op(1'b1, {4'h4, a[3:0]}, d);
    repeat (6) begin
      @(negedge clk);
      cmp_lvl({irq_defer, cpu_hold}, 2'b00);
    end
    st(flash_ctrl_pkg::ST_UNLOCKED);
    mrd(a, FF);
    mrd({4'h4, a[3:0]}, FF);
    wr(CS, flash_ctrl_pkg::CMD_PAGE_ERASE);
    st(flash_ctrl_pkg::ST_LOCKED);
    i_cpu_model.open_page(8'h03);
    wr(CS, flash_ctrl_pkg::CMD_UNLOCK2);
    wr(CS, flash_ctrl_pkg::CMD_MASS_ERASE);
    st(flash_ctrl_pkg::ST_LOCKED);
    $display("test write_protect done");
    wr(CS, flash_ctrl_pkg::CMD_RESET);
    rd(PP, 8'h03);
    wr(CS, flash_ctrl_pkg::CMD_PROT_SEL);
    st(flash_ctrl_pkg::ST_PROT_SEL);
    wr(PP, 8'h05);
    wr(PP, 8'h02);
    rd(PP, 8'h07);
    wr(CS, flash_ctrl_pkg::CMD_RESET);
    st(flash_ctrl_pkg::ST_LOCKED);
    rd(PP, 8'h03);
    $display("test protect_select done");
    do_reset();
    rd(PP, flash_ctrl_pkg::PAGE_RESET_VAL);
    $display("test second_reset done");
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire
